// file: verification/ppsc_chipset.sv
`timescale 1ns/10ps
// Far side: answers save and ack requests, cuts power on trip
module ppsc_chipset (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic SLOW,
  input wire logic STATE_SAVE,
  input wire logic ACK_REQ,
  input wire logic THERMAL_TRIP_N,
  output logic SAVE_DONE,
  output logic ACK_DONE,
  output logic PWR_OFF
);
  logic [2:0] cnt_r; // Cycles waited on the open request
  logic done_r; // One-cycle answer
  // Slow answers wait five cycles; the answer drops right after
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_r <= 3'h0;
      done_r <= 1'b0;
    end else if ((STATE_SAVE || ACK_REQ) && !done_r) begin
      done_r <= cnt_r == (SLOW ? 3'h4 : 3'h0);
      cnt_r <= cnt_r + 3'h1;
    end else begin
      done_r <= 1'b0;
      cnt_r <= 3'h0;
    end
  end
  assign SAVE_DONE = done_r & STATE_SAVE;
  assign ACK_DONE = done_r & ACK_REQ;
  assign PWR_OFF = !THERMAL_TRIP_N;
endmodule : ppsc_chipset

// file: verification/ppsc_ctrl_properties.sv
`timescale 1ns/10ps
module ppsc_ctrl_properties (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic CLOCK_STOP_REQ_N,
  input wire logic [7:0] TEMP_DEG_C,
  input wire logic ACK_DONE,
  input wire logic THERMAL_TRIP_N,
  input wire logic OUT_EN,
  input wire logic STATE_SAVE,
  input wire logic ACK_REQ,
  input wire ppsc_pkg::ppsc_ack_t ACK_CODE,
  input wire logic CORE_CLK_EN,
  input wire logic BUS_CLK_EN,
  input wire logic INTCTRL_CLK_EN,
  input wire logic SNOOP_EN,
  input wire logic EXEC_EN,
  input wire logic CORE_RESET,
  input wire logic [31:0] FETCH_VECTOR
);
  import ppsc_pkg::*;
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // Sensor at or above the trip point
  wire hot = TEMP_DEG_C >= 8'd135;
  ////////////////////////////////////////////////////////////////////////
  a_sync_two_stage: assert property (
    CE && $fell(CLOCK_STOP_REQ_N) && !ACK_REQ && !STATE_SAVE
    |-> !ACK_REQ [*3]) else $error("stop request acted on too early");
  a_hot_trips: assert property (
    CE && hot && !CORE_RESET |=> !THERMAL_TRIP_N || CORE_RESET)
    else $error("hot sensor did not trip");
  a_trip_stops_core: assert property (
    !THERMAL_TRIP_N |-> !CORE_CLK_EN && !EXEC_EN)
    else $error("core still running in trip");
  a_trip_min_hold: assert property (
    $fell(THERMAL_TRIP_N) |-> !THERMAL_TRIP_N [*8])
    else $error("trip released too soon");
  a_trip_core_reset: assert property (
    $rose(THERMAL_TRIP_N) |-> CORE_RESET && FETCH_VECTOR == 32'hFFFFFFF0
    ##1 !CORE_RESET) else $error("no single reset pulse after trip");
  a_halt_keeps_bus: assert property (
    !CORE_CLK_EN && THERMAL_TRIP_N && !CORE_RESET
    |-> BUS_CLK_EN && INTCTRL_CLK_EN && SNOOP_EN)
    else $error("bus side gated in halt");
  a_ack_stands: assert property (
    CE && ACK_REQ && !ACK_DONE && !hot |=> ACK_REQ && $stable(ACK_CODE))
    else $error("ack request dropped early");
  a_float_held: assert property (
    !OUT_EN |=> !OUT_EN) else $error("float state left without reset");
  // Main scenarios reached
  cover property ($fell(THERMAL_TRIP_N));
  cover property (ACK_DONE && ACK_CODE == 2'h2);
  cover property (!OUT_EN);
endmodule : ppsc_ctrl_properties

bind ppsc_ctrl ppsc_ctrl_properties u_props (.CLK(CLK), .NRST(NRST),
  .CE(CE), .CLOCK_STOP_REQ_N(CLOCK_STOP_REQ_N), .TEMP_DEG_C(TEMP_DEG_C),
  .ACK_DONE(ACK_DONE), .THERMAL_TRIP_N(THERMAL_TRIP_N), .OUT_EN(OUT_EN),
  .STATE_SAVE(STATE_SAVE), .ACK_REQ(ACK_REQ), .ACK_CODE(ACK_CODE),
  .CORE_CLK_EN(CORE_CLK_EN), .BUS_CLK_EN(BUS_CLK_EN),
  .INTCTRL_CLK_EN(INTCTRL_CLK_EN), .SNOOP_EN(SNOOP_EN), .EXEC_EN(EXEC_EN),
  .CORE_RESET(CORE_RESET), .FETCH_VECTOR(FETCH_VECTOR));

// file: verification/tb_processor_power_state_control.sv
`timescale 1ns/10ps
`define CHK(a,b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
`define WT(c) begin for (int k = 0; k < 60 && !(c); k++) @(negedge clk); \
  if (!(c)) begin n_fail++; test_done(); end end
module tb_processor_power_state_control;
  logic clk = 0, nrst = 0, irq_n = 1, stop_n = 1, mexit = 0, slow = 0;
  logic [7:0] temp = 8'h19; // Cool sensor
  int n_fail = 0, n_tests = 0;
  logic trip_n, out_en, mmode, save, hstart, ack, core_en, bus_en, ic_en;
  logic snoop, exec, crst, sdone, adone;
  ppsc_pkg::ppsc_ack_t code;
  logic [31:0] vec;
  always #4 clk = ~clk;
  ppsc_chipset u_cs (.CLK(clk), .NRST(nrst), .SLOW(slow), .STATE_SAVE(save),
    .ACK_REQ(ack), .THERMAL_TRIP_N(trip_n), .SAVE_DONE(sdone),
    .ACK_DONE(adone), .PWR_OFF());
  ppsc_ctrl dut (.CLK(clk), .NRST(nrst), .CE(1'b1), .MGMT_IRQ_N(irq_n),
    .CLOCK_STOP_REQ_N(stop_n), .TEMP_DEG_C(temp), .SAVE_DONE(sdone),
    .ACK_DONE(adone), .MGMT_EXIT(mexit), .THERMAL_TRIP_N(trip_n),
    .OUT_EN(out_en), .MGMT_MODE(mmode), .STATE_SAVE(save),
    .HANDLER_START(hstart), .ACK_REQ(ack), .ACK_CODE(code),
    .CORE_CLK_EN(core_en), .BUS_CLK_EN(bus_en), .INTCTRL_CLK_EN(ic_en),
    .SNOOP_EN(snoop), .EXEC_EN(exec), .CORE_RESET(crst), .FETCH_VECTOR(vec));
  task test_done;
    $display("fails %0d checks %0d", n_fail, n_tests);
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task do_reset;
    nrst = 0;
    repeat (20) @(negedge clk);
    nrst = 1;
    repeat (3) @(negedge clk);
  endtask : do_reset
  task test_mgmt;
    slow = 1;
    irq_n = 0;
    `WT(save === 1'b1)
    // Drop the request now, so it has left the synchroniser at exit
    irq_n = 1;
    `CHK(mmode, 1'b0)
    `WT(ack === 1'b1)
    `CHK({mmode, code}, 3'h5)
    `WT(hstart === 1'b1)
    `CHK(ack, 1'b0)
    mexit = 1;
    @(negedge clk);
    mexit = 0;
    @(negedge clk);
    `CHK(mmode, 1'b0)
    $display("mgmt test done");
  endtask : test_mgmt
  task test_stop;
    slow = 0;
    stop_n = 0;
    `WT(ack === 1'b1)
    `CHK(code, 2'h2)
    `WT(core_en === 1'b0)
    `CHK({exec, ic_en, snoop, bus_en}, 4'h7)
    stop_n = 1;
    `WT(core_en === 1'b1)
    `CHK(exec, 1'b1)
    $display("stop test done");
  endtask : test_stop
  task test_trip;
    temp = 8'd134; // Just below the trip point
    repeat (6) @(negedge clk);
    `CHK(trip_n, 1'b1)
    temp = 8'd135;
    `WT(trip_n === 1'b0)
    `CHK({core_en, exec, bus_en}, 3'h1)
    `WT(crst === 1'b1)
    `CHK(vec, 32'hFFFFFFF0)
    `WT(trip_n === 1'b0)
    `CHK(core_en, 1'b0)
    nrst = 0;
    #1;
    `CHK(trip_n, 1'b1)
    temp = 8'h19;
    do_reset();
    $display("trip test done");
  endtask : test_trip
  task test_float;
    irq_n = 0; // Held low across reset release
    do_reset();
    `CHK(out_en, 1'b0)
    irq_n = 1;
    do_reset();
    `CHK(out_en, 1'b1)
    $display("float test done");
  endtask : test_float
  // Main sequence
  initial begin
    do_reset();
    test_mgmt();
    test_stop();
    test_trip();
    test_float();
    test_done();
  end
endmodule : tb_processor_power_state_control

// file: verilog/ppsc_ctrl.sv
`timescale 1ns/10ps
`include "ppsc_map.svh"

// Behaviour
// [R1] Management interrupt request is asynchronous
// [R2] On request, save state, enter management mode
// [R3] Issue management ack, then run handler
// [R4] Request held during reset release: outputs float
// [R5] Clock-stop request held enters halted state
// [R6] Halted entry issues halt ack transaction
// [R7] Halted gates core clocks, bus and intctrl run
// [R8] Halted keeps snooping and servicing interrupts
// [R9] Clock-stop release restarts clocks, resumes
// [R10] Bus clock untouched, only internal clocks gated
// [R11] Trip output asserts at sensor threshold
// [R12] Trip stops clocks and execution together
// [R13] Trip resets core, restarts at boot vector
// [R14] Still hot after reset: trip again
// [R15] System reset releases trip output
// [R16] System removes power on trip
// [R17] Two-stage synchroniser on async inputs
module ppsc_ctrl #(
  parameter int CNT_W = `PPSC_CNT_W
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic MGMT_IRQ_N,
  input wire logic CLOCK_STOP_REQ_N,
  input wire logic [7:0] TEMP_DEG_C,
  input wire logic SAVE_DONE,
  input wire logic ACK_DONE,
  input wire logic MGMT_EXIT,
  output logic THERMAL_TRIP_N,
  output logic OUT_EN,
  output logic MGMT_MODE,
  output logic STATE_SAVE,
  output logic HANDLER_START,
  output logic ACK_REQ,
  output ppsc_pkg::ppsc_ack_t ACK_CODE,
  output logic CORE_CLK_EN,
  output logic BUS_CLK_EN,
  output logic INTCTRL_CLK_EN,
  output logic SNOOP_EN,
  output logic EXEC_EN,
  output logic CORE_RESET,
  output logic [31:0] FETCH_VECTOR
);
  import ppsc_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  logic [1:0] sync_q; // Synchronised {clock stop, mgmt irq}, active low
  logic mgmt_req; // Management request, active high
  logic stop_req; // Clock-stop request, active high
  logic hot; // Sensor at or above trip level

  // Both async requests go through two flops before any decision [R1] [R17]
  ppsc_sync #(.W(2), .INIT(2'h3)) u_sync (
    .CLK(CLK),
    .NRST(NRST),
    .CE(CE),
    .D({CLOCK_STOP_REQ_N, MGMT_IRQ_N}),
    .Q(sync_q)
  );

  assign mgmt_req = ~sync_q[0];
  assign stop_req = ~sync_q[1];
  assign hot = (TEMP_DEG_C >= `PPSC_TRIP_DEG_C); // [R11]

  //////////////////////////////////////////////////////////////////////////
  // Reset release strap
  // The synchroniser is held in reset too, so for the first two enabled
  // edges after release it still shows the idle level of the pin. The
  // strap is therefore taken at the third enabled edge, when the level
  // seen just after release has come through both flops. Limitation: a
  // request raised before the first enabled edge counts as held across release;
  // that is the price of a sample free of metastability.
  logic [1:0] strap_wait_r; // Enabled edges since release, stops at 2
  logic strap_done_r; // Strap already sampled
  logic float_r; // Outputs floated until next system reset

  // Count the edges the synchroniser needs to flush its reset value
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      strap_wait_r <= 2'h0;
    end else if (CE && strap_wait_r != 2'h2) begin
      strap_wait_r <= strap_wait_r + 2'h1;
    end
  end

  // Strap window closes at the third enabled edge after release
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      strap_done_r <= 1'b0;
    end else if (CE && !strap_done_r && strap_wait_r == 2'h2) begin
      strap_done_r <= 1'b1;
    end
  end

  // Request seen at release latches the float mode [R4]
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      float_r <= 1'b0;
    end else if (CE && !strap_done_r && mgmt_req) begin
      float_r <= 1'b1; // [R4]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Main state machine
  ppsc_state_t state_r; // Current power state
  ppsc_state_t state_nxt; // Next power state
  logic [CNT_W-1:0] cnt_r; // Trip hold counter
  logic trip_end; // Trip hold has elapsed

  assign trip_end = (cnt_r == CNT_W'(`PPSC_TRIP_HOLD_CYC - 1));

  // Next-state decision; thermal trip has top priority once the strap is sampled
  always_comb begin
    state_nxt = state_r;
    if (!strap_done_r) begin
      state_nxt = PPSC_RUN; // Wait for the strap sample first
    end else if (hot && state_r != PPSC_TRIP) begin
      state_nxt = PPSC_TRIP; // [R11] [R14]
    end else begin
      case (state_r)
        PPSC_RUN: begin
          // Management wins over clock stop when both arrive
          if (mgmt_req) begin
            state_nxt = PPSC_SAVE; // [R2]
          end else if (stop_req) begin
            state_nxt = PPSC_HALT_ACK; // [R5]
          end
        end
        PPSC_SAVE: begin
          if (SAVE_DONE) begin
            state_nxt = PPSC_MGMT_ACK; // [R2]
          end
        end
        PPSC_MGMT_ACK: begin
          if (ACK_DONE) begin
            state_nxt = PPSC_MGMT; // [R3]
          end
        end
        PPSC_MGMT: begin
          if (MGMT_EXIT) begin
            state_nxt = PPSC_RUN;
          end
        end
        PPSC_HALT_ACK: begin
          if (ACK_DONE) begin
            state_nxt = PPSC_HALT; // [R6]
          end
        end
        PPSC_HALT: begin
          if (!stop_req) begin
            state_nxt = PPSC_RUN; // [R9]
          end
        end
        PPSC_TRIP: begin
          // Internal reset after the hold; re-trips if still hot [R13] [R14]
          if (trip_end) begin
            state_nxt = PPSC_RUN;
          end
        end
        default: begin
          state_nxt = PPSC_RUN;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= PPSC_RUN;
    end else if (CE) begin
      state_r <= state_nxt;
    end
  end

  // Trip hold counter runs only in the trip state
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_r <= '0;
    end else if (CE) begin
      if (state_r == PPSC_TRIP && !trip_end) begin
        cnt_r <= cnt_r + CNT_W'(1);
      end else begin
        cnt_r <= '0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs, decoded from the next state except OUT_EN
  // Decoding from the next state rather than the current one costs a
  // wider cone ahead of each output flop, but lets every pin change on
  // the same edge as the state register. Pins then never lag the state
  // by a cycle, and no output is driven from a gate.
  logic entering; // State changes this cycle

  assign entering = (state_nxt != state_r);

  // Thermal trip pin; system reset clears it even when hot [R15] [R16]
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      THERMAL_TRIP_N <= 1'b1; // [R15]
    end else if (CE) begin
      THERMAL_TRIP_N <= ~(state_nxt == PPSC_TRIP); // [R11] [R14]
    end
  end

  // Output enable drops for good in float mode [R4]
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      OUT_EN <= 1'b1;
    end else if (CE) begin
      OUT_EN <= ~(float_r | (!strap_done_r & mgmt_req)); // [R4]
    end
  end

  // Management mode flags and save / handler strobes
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      MGMT_MODE <= 1'b0;
      STATE_SAVE <= 1'b0;
      HANDLER_START <= 1'b0;
    end else if (CE) begin
      MGMT_MODE <= (state_nxt == PPSC_MGMT_ACK) ||
        (state_nxt == PPSC_MGMT); // [R2]
      STATE_SAVE <= (state_nxt == PPSC_SAVE); // [R2]
      HANDLER_START <= entering && (state_nxt == PPSC_MGMT); // [R3]
    end
  end

  // Special acknowledge transaction request, held until ACK_DONE
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ACK_REQ <= 1'b0;
      ACK_CODE <= '0;
    end else if (CE) begin
      if (state_nxt == PPSC_MGMT_ACK) begin
        ACK_REQ <= 1'b1; // [R3]
        ACK_CODE <= `PPSC_ACK_MGMT;
      end else if (state_nxt == PPSC_HALT_ACK) begin
        ACK_REQ <= 1'b1; // [R6]
        ACK_CODE <= `PPSC_ACK_HALT;
      end else begin
        ACK_REQ <= 1'b0;
        ACK_CODE <= '0;
      end
    end
  end

  // Clock enables; bus clock stays on in every state, trip included [R7] [R10] [R12]
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      CORE_CLK_EN <= 1'b1;
      BUS_CLK_EN <= 1'b1;
      INTCTRL_CLK_EN <= 1'b1;
      SNOOP_EN <= 1'b1;
    end else if (CE) begin
      CORE_CLK_EN <= (state_nxt != PPSC_HALT) &&
        (state_nxt != PPSC_TRIP); // [R7] [R9] [R12]
      BUS_CLK_EN <= 1'b1; // [R10]
      INTCTRL_CLK_EN <= (state_nxt != PPSC_TRIP); // [R7] [R8]
      SNOOP_EN <= (state_nxt != PPSC_TRIP); // [R8]
    end
  end

  // Execution enable; halted and trip stop the program [R9] [R12]
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      EXEC_EN <= 1'b0;
    end else if (CE) begin
      EXEC_EN <= strap_done_r && !float_r &&
        (state_nxt == PPSC_RUN || state_nxt == PPSC_MGMT); // [R9] [R12]
    end
  end

  // Internal reset pulse and boot vector at trip exit [R13]
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      CORE_RESET <= 1'b1;
      FETCH_VECTOR <= `PPSC_BOOT_VECTOR;
    end else if (CE) begin
      CORE_RESET <= !strap_done_r ||
        (state_r == PPSC_TRIP && state_nxt == PPSC_RUN); // [R13]
      if (state_r == PPSC_TRIP && state_nxt == PPSC_RUN) begin
        FETCH_VECTOR <= `PPSC_BOOT_VECTOR; // [R13]
      end
    end
  end

endmodule : ppsc_ctrl

// file: verilog/ppsc_map.svh
`ifndef PPSC_MAP_SVH
`define PPSC_MAP_SVH

// Trip threshold of the sensor, degrees Celsius
`define PPSC_TRIP_DEG_C 8'd135
// Least time the trip output is held active before the internal reset, ns
`define PPSC_TRIP_HOLD_NS 64
// Clock period in ns
`define PPSC_CLK_PERIOD_NS 8
// Trip hold in clock cycles, rounded up
`define PPSC_TRIP_HOLD_CYC \
  ((`PPSC_TRIP_HOLD_NS + `PPSC_CLK_PERIOD_NS - 1) / `PPSC_CLK_PERIOD_NS)
// Width of the trip hold counter
`define PPSC_CNT_W 4
// Boot vector reset value
`define PPSC_BOOT_VECTOR 32'hFFFFFFF0
// Bus transaction codes for the special acknowledge cycles
`define PPSC_ACK_MGMT 2'h1
`define PPSC_ACK_HALT 2'h2

`endif

// file: verilog/ppsc_pkg.sv
package ppsc_pkg;
  // Power state of the core
  typedef enum logic [2:0] {
    PPSC_RUN,
    PPSC_SAVE,
    PPSC_MGMT_ACK,
    PPSC_MGMT,
    PPSC_HALT_ACK,
    PPSC_HALT,
    PPSC_TRIP
  } ppsc_state_t;
  // Special bus transaction code
  typedef logic [1:0] ppsc_ack_t;
endpackage : ppsc_pkg

// file: verilog/ppsc_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser, one per bit
module ppsc_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_r; // First stage, read only by the second
      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          meta_r <= INIT[i];
          Q[i] <= INIT[i];
        end else if (CE) begin
          meta_r <= D[i];
          Q[i] <= meta_r;
        end
      end
    end
  endgenerate
endmodule : ppsc_sync
